/* File: debug_trigger_regs.vh */
// register indices, field positions, codes and reset values of the trigger block
`ifndef DEBUG_TRIGGER_REGS_VH
`define DEBUG_TRIGGER_REGS_VH

// register indices, byte address is four times the index
`define IDX_CONTROL      8'h0c
`define IDX_TRIGGER      8'h0d
`define IDX_STATUS       8'h0e
`define IDX_COUNT        8'h0f
`define IDX_IRQ_STATUS   8'h10
`define IDX_IRQ_MASK     8'h11

// unit_control_reg fields
`define CTL_ENABLE_BIT   7
`define CTL_ARM_BIT      6
// trigger_setup fields
`define TRG_QUAL_BIT     7
`define TRG_BEGIN_BIT    6
`define TRG_MODE_HI      3
`define TRG_MODE_LO      0
// match_status fields
`define ST_A_BIT         7
`define ST_B_BIT         6
`define ST_C_BIT         5
`define ST_ARMED_BIT     0
// interrupt status and mask fields
`define IRQ_TRIG_BIT     0
`define IRQ_FULL_BIT     1
`define IRQ_END_BIT      2

// trigger mode codes
`define MODE_A_ONLY      4'h0
`define MODE_A_OR_B      4'h1
`define MODE_A_THEN_B    4'h2
`define MODE_EV_B        4'h3
`define MODE_A_THEN_EV_B 4'h4
`define MODE_A_AND_B     4'h5
`define MODE_A_AND_NOT_B 4'h6
`define MODE_INSIDE      4'h7
`define MODE_OUTSIDE     4'h8

// reset values and limits
`define RST_CONTROL      8'h00
`define RST_TRIGGER      8'h00
`define RST_COUNT        4'h0
`define RST_IRQ          3'h0
`define COUNT_FULL       4'h8

`endif

/* File: debug_trigger_status_count.v */
// trigger setup, match status and capture count of the on-chip trace unit
//
// Decided for this implementation: register access over APB.
`include "debug_trigger_regs.vh"
`default_nettype none

// Function
// - qualify bit 0 triggers on any compare access, 1 only on executed opcode except for event B, inside and outside
// - begin/end bit: 0 trigger ends storage, 1 trigger starts storage
// - codes 0000..0100: A, A or B, A then B, event B, A then event B
// - codes 0101..1000: A and B, A and not B, inside, outside; others none
// - trigger setup register holds while armed, writable only when disarmed
// - end-run reset of enabled end-type run keeps trigger setup bits
// - match A flag bit 7 set once A matched since arming
// - match B flag bit 6 reports B matched since arming
// - match C flag bit 5 reports C matched since arming
// - armed flag bit 0 copies the arm control bit while enabled
// - end-run reset clears armed flag, match flags keep their values
// - capture count increments per captured word, saturates at eight
// - capture count clears when armed, value equals valid fifo words
// - end-run reset keeps count; power-on or other reset clears it
// - arming, triggering and storage only while unit enabled
// - begin-type run stores after trigger until eight words held
module debug_trigger_status_count (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        run_reset,
  input  wire        bus_access,
  input  wire        match_a,
  input  wire        match_b,
  input  wire        match_c,
  input  wire        exec_a,
  input  wire        exec_b,
  input  wire        word_valid,
  output wire        fifo_write,
  output wire        storing,
  output reg         trigger_pulse,
  output wire        irq
);

  // registers
  reg        enable_reg;
  reg        arm_reg;
  reg  [7:0] setup_reg;
  reg        flag_a_reg;
  reg        flag_b_reg;
  reg        flag_c_reg;
  reg  [3:0] count_reg;
  reg        seen_a_reg;
  reg        started_reg;
  reg  [2:0] irq_stat_reg;
  reg  [2:0] irq_mask_reg;
  reg [31:0] prdata_reg;

  // decoded controls
  wire       qual_sel;
  wire       begin_type;
  wire [3:0] mode;
  wire       wr_access;
  wire       rd_setup;
  wire       wr_control;
  wire       wr_setup;
  wire       wr_irq_stat;
  wire       wr_irq_mask;
  wire       arm_request;
  wire       keep_case;
  wire       active;
  wire       hit_a;
  wire       hit_b;
  wire       count_full;
  wire       disarm_write;
  wire       last_word;
  wire       trig_event;
  wire       full_event;
  wire       end_event;
  wire [7:0] control_word;
  wire [7:0] status_word;

  reg        trig_now;
  reg  [31:0] rd_mux;
  reg        mapped;
  reg        arm_next;
  reg        started_next;
  reg  [3:0] count_next;

  // reset value of the control register, split into enable and arm
  localparam [7:0] control_init = `RST_CONTROL;
  localparam [0:0] enable_init  = control_init[`CTL_ENABLE_BIT];
  localparam [0:0] arm_init     = control_init[`CTL_ARM_BIT];

  // true when a byte address selects a register index
  function hit;
    input [11:0] addr;
    input [7:0]  idx;
    begin
      hit = (addr[1:0] == 2'b00) && (addr[11:2] == {2'b00, idx});
    end
  endfunction

  // zero-extend an 8-bit value onto the bus
  function [31:0] wide8;
    input [7:0] v;
    begin
      wide8 = {24'h000000, v};
    end
  endfunction

  assign qual_sel   = setup_reg[`TRG_QUAL_BIT];
  assign begin_type = setup_reg[`TRG_BEGIN_BIT];
  assign mode       = setup_reg[`TRG_MODE_HI:`TRG_MODE_LO];

  // bus decode, writes land in the access phase
  assign wr_access   = psel & penable & pwrite;
  assign rd_setup    = psel & ~penable & ~pwrite;
  assign wr_control  = wr_access & hit(paddr, `IDX_CONTROL);
  assign wr_setup    = wr_access & hit(paddr, `IDX_TRIGGER);
  assign wr_irq_stat = wr_access & hit(paddr, `IDX_IRQ_STATUS);
  assign wr_irq_mask = wr_access & hit(paddr, `IDX_IRQ_MASK);

  assign arm_request = wr_control & pwdata[`CTL_ENABLE_BIT] & pwdata[`CTL_ARM_BIT] & ~arm_reg;

  // enabled end-type run ending in reset keeps its state
  assign keep_case = run_reset & enable_reg & ~begin_type;

  // nothing triggers or stores while disabled
  assign active = enable_reg & arm_reg & ~run_reset;

  // pick the executed-opcode match or the raw match
  function qualify;
    input sel;
    input executed;
    input raw;
    begin
      qualify = sel ? executed : raw;
    end
  endfunction

  // opcode qualification of A and B
  assign hit_a = qualify(qual_sel, exec_a, match_a);
  assign hit_b = qualify(qual_sel, exec_b, match_b);

  assign count_full = (count_reg == `COUNT_FULL);

  // writing enable or arm low ends a run
  assign disarm_write = wr_control & (~pwdata[`CTL_ARM_BIT] | ~pwdata[`CTL_ENABLE_BIT]);

  // eighth word of a run goes into the fifo this cycle
  assign last_word = fifo_write & (count_reg == (`COUNT_FULL - 4'h1));

  // trigger condition by mode
  always @* begin
    trig_now = 1'b0;
    case (mode)
      `MODE_A_ONLY:      trig_now = hit_a;
      `MODE_A_OR_B:      trig_now = hit_a | hit_b;
      `MODE_A_THEN_B:    trig_now = seen_a_reg & hit_b;
      `MODE_EV_B:        trig_now = match_b;
      `MODE_A_THEN_EV_B: trig_now = seen_a_reg & match_b;
      `MODE_A_AND_B:     trig_now = hit_a & hit_b;
      `MODE_A_AND_NOT_B: trig_now = hit_a & ~hit_b;
      `MODE_INSIDE:      trig_now = bus_access & match_a & match_b;
      `MODE_OUTSIDE:     trig_now = bus_access & ~(match_a & match_b);
      default:           trig_now = 1'b0; // codes 9..15 never trigger
    endcase
  end

  // storage window: end-type before trigger, begin-type after
  assign storing    = active & (begin_type ? started_reg : ~trig_now);
  assign fifo_write = storing & word_valid;

  // next arm and started bits; resets and disarming writes win over the run
  always @* begin
    arm_next     = arm_reg;
    started_next = started_reg;
    if (run_reset) begin
      arm_next     = 1'b0;
      started_next = 1'b0;
    end else if (arm_request) begin
      arm_next     = 1'b1;
      started_next = 1'b0;
    end else if (disarm_write) begin
      arm_next = 1'b0;
    end else if (active) begin
      if (!begin_type && trig_now) begin
        arm_next = 1'b0;
      end else if (begin_type && !started_reg && trig_now) begin
        started_next = 1'b1;
      end else if (begin_type && started_reg && last_word) begin
        // run ends with eight words stored
        arm_next     = 1'b0;
        started_next = 1'b0;
      end
    end
  end

  // interrupt events: trigger, eighth word, end of a run for any reason
  assign trig_event = active & trig_now & ~(begin_type & started_reg);
  assign full_event = last_word;
  assign end_event  = arm_reg & ~arm_next;

  // control register and run sequencing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg    <= enable_init;
      arm_reg       <= arm_init;
      started_reg   <= 1'b0;
      seen_a_reg    <= 1'b0;
      trigger_pulse <= 1'b0;
    end else begin
      arm_reg     <= arm_next;
      started_reg <= started_next;
      if (run_reset) begin
        // end-run reset keeps enable, other resets clear it
        enable_reg    <= keep_case ? enable_reg : 1'b0;
        seen_a_reg    <= 1'b0;
        trigger_pulse <= 1'b0;
      end else begin
        trigger_pulse <= trig_event;
        if (wr_control) begin
          enable_reg <= pwdata[`CTL_ENABLE_BIT];
        end
        if (arm_request) begin
          seen_a_reg <= 1'b0;
        end else if (active && !disarm_write && hit_a) begin
          seen_a_reg <= 1'b1;
        end
      end
    end
  end

  // trigger setup register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_reg <= `RST_TRIGGER;
    end else if (run_reset) begin
      // kept on enabled end-type run reset
      if (!keep_case) begin
        setup_reg <= `RST_TRIGGER;
      end
    end else if (wr_setup && !arm_reg) begin
      // writes while armed are dropped silently
      setup_reg <= {pwdata[7:6], 2'b00, pwdata[3:0]};
    end
  end

  // match flags since arming
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_a_reg <= 1'b0;
      flag_b_reg <= 1'b0;
      flag_c_reg <= 1'b0;
    end else if (run_reset) begin
      // flags keep values on end-run reset
      if (!keep_case) begin
        flag_a_reg <= 1'b0;
        flag_b_reg <= 1'b0;
        flag_c_reg <= 1'b0;
      end
    end else if (arm_request) begin
      flag_a_reg <= 1'b0;
      flag_b_reg <= 1'b0;
      flag_c_reg <= 1'b0;
    end else if (active) begin
      if (hit_a) begin
        flag_a_reg <= 1'b1;
      end
      if (hit_b) begin
        flag_b_reg <= 1'b1;
      end
      if (match_c) begin
        flag_c_reg <= 1'b1;
      end
    end
  end

  // next capture count
  always @* begin
    count_next = count_reg;
    if (run_reset) begin
      // kept on end-run reset, cleared otherwise
      if (!keep_case) begin
        count_next = `RST_COUNT;
      end
    end else if (arm_request) begin
      count_next = `RST_COUNT;
    end else if (fifo_write && !count_full) begin
      // one per word, stops at eight
      count_next = count_reg + 4'h1;
    end
  end

  // capture count register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= `RST_COUNT;
    end else begin
      count_reg <= count_next;
    end
  end

  // interrupt status and mask, set wins over clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= `RST_IRQ;
      irq_mask_reg <= `RST_IRQ;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~(wr_irq_stat ? pwdata[2:0] : 3'h0))
                    | {end_event, full_event, trig_event};
      if (wr_irq_mask) begin
        irq_mask_reg <= pwdata[2:0];
      end
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // control register as read back
  assign control_word = {enable_reg, arm_reg, 6'h00};

  // armed flag mirrors arm while enabled
  assign status_word = {flag_a_reg, flag_b_reg, flag_c_reg, 4'h0, arm_reg & enable_reg};

  // read multiplexer
  always @* begin
    rd_mux = 32'h00000000;
    mapped = 1'b1;
    if (hit(paddr, `IDX_CONTROL)) begin
      rd_mux = wide8(control_word);
    end else if (hit(paddr, `IDX_TRIGGER)) begin
      rd_mux = wide8(setup_reg);
    end else if (hit(paddr, `IDX_STATUS)) begin
      rd_mux = wide8(status_word);
    end else if (hit(paddr, `IDX_COUNT)) begin
      rd_mux = wide8({4'h0, count_reg});
    end else if (hit(paddr, `IDX_IRQ_STATUS)) begin
      rd_mux = {29'h00000000, irq_stat_reg};
    end else if (hit(paddr, `IDX_IRQ_MASK)) begin
      rd_mux = {29'h00000000, irq_mask_reg};
    end else begin
      mapped = 1'b0;
    end
  end

  // read data captured in the setup phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (rd_setup) begin
      prdata_reg <= rd_mux;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

endmodule // debug_trigger_status_count

`default_nettype wire

/* File: dtsc_checker_sva.sv */
// port checker for the trigger setup, status and count block
`default_nettype none
module dtsc_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        run_reset,
  input wire logic        word_valid,
  input wire logic        fifo_write,
  input wire logic        storing,
  input wire logic        trigger_pulse
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // access phase, read access and decode of the register window
  wire acc = psel && penable;
  wire rd = acc && !pwrite;
  wire hit = paddr >= 12'h030 && paddr <= 12'h044 && paddr[1:0] == 2'b00;
  a_unmapped_err: assert property (acc && !hit |-> pslverr)
    else $error("no error on unmapped access");
  a_mapped_ok: assert property (acc && hit |-> !pslverr)
    else $error("error on mapped access");
  a_upper_zero: assert property (rd |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_count_limit: assert property (rd && paddr == 12'h03c |-> prdata[7:0] <= 8'h08)
    else $error("count above eight");
  a_status_gap: assert property (rd && paddr == 12'h038 |-> prdata[4:1] == 4'h0)
    else $error("unused status bits set");
  a_store_cause: assert property (fifo_write |-> word_valid && storing)
    else $error("store without word or window");
  a_reset_stops: assert property (run_reset |=> !storing)
    else $error("storing after run reset");
  a_disable_stops: assert property (
    acc && pwrite && paddr == 12'h030 && !pwdata[7] |=> !storing [*2])
    else $error("storing after disable");
  a_pulse_single: assert property (trigger_pulse |=> !trigger_pulse)
    else $error("trigger pulse too long");
endmodule // dtsc_checker
bind debug_trigger_status_count dtsc_checker u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pslverr, .run_reset, .word_valid, .fifo_write,
  .storing, .trigger_pulse);
`default_nettype wire

/* File: core_bus_model.sv */
// cycle-level model of the core bus comparators and capture source
`default_nettype none
module core_bus_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [6:0] ev,
  output var  logic       word_valid,
  output var  logic       bus_access,
  output var  logic       match_a,
  output var  logic       match_b,
  output var  logic       match_c,
  output var  logic       exec_a,
  output var  logic       exec_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // one commanded event per cycle, launched on the edge after the request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {word_valid, bus_access, match_a, match_b, match_c, exec_a, exec_b} <= 7'h00;
    end else begin
      {word_valid, bus_access, match_a, match_b, match_c, exec_a, exec_b} <= ev;
    end
  end
endmodule // core_bus_model
`default_nettype wire

/* File: test_debug_trigger_status_count.sv */
// self-checking bench of the trigger setup, match status and capture count
`include "debug_trigger_regs.vh"
`default_nettype none
module test_debug_trigger_status_count;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] WV = 7'h40, BUS = 7'h20, A = 7'h10, B = 7'h08, C = 7'h04;
  localparam logic [6:0] XA = 7'h02, N = 7'h00;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, q;
  logic        run_reset = 1'b0, last_err;
  logic [6:0]  ev = 7'h00;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq, word_valid, bus_access;
  wire         match_a, match_b, match_c, exec_a, exec_b;
  int          err_count = 0, num_checks = 0, cyc = 0;
  // setup value, first and second event, trigger expected
  logic [22:0] rows [18] = '{{8'h00, A, N, 1'b1}, {8'h00, B, N, 1'b0}, {8'h01, B, N, 1'b1},
    {8'h02, B, A, 1'b0}, {8'h02, A, B, 1'b1}, {8'h03, B, N, 1'b1}, {8'h04, A, B, 1'b1},
    {8'h04, B, N, 1'b0}, {8'h05, A | B, N, 1'b1}, {8'h05, A, N, 1'b0}, {8'h06, A, N, 1'b1},
    {8'h06, A | B, N, 1'b0}, {8'h07, BUS | A | B, N, 1'b1}, {8'h07, A | B, N, 1'b0},
    {8'h08, BUS | A, N, 1'b1}, {8'h08, BUS | A | B, N, 1'b0}, {8'h0f, BUS | A | B, N, 1'b0},
    {8'h80, A, N, 1'b0}};
  always #5 pclk = ~pclk;
  debug_trigger_status_count dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .run_reset, .bus_access, .match_a, .match_b,
    .match_c, .exec_a, .exec_b, .word_valid, .fifo_write(), .storing(), .trigger_pulse(),
    .irq);
  core_bus_model u_core (.pclk, .presetn, .ev, .word_valid, .bus_access, .match_a,
    .match_b, .match_c, .exec_a, .exec_b);
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one register transfer: setup edge, access until pready, then release
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    check(q, exp);
  endtask
  // hold one event pattern for n cycles, then let it settle
  task automatic drive(input logic [6:0] v, input int n);
    ev <= v;
    repeat (n) @(posedge pclk);
    ev <= 7'h00;
    repeat (3) @(posedge pclk);
  endtask
  task automatic pulse_reset();
    run_reset <= 1'b1;
    @(posedge pclk);
    run_reset <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // cut a hang short
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      test_done();
    end
  end
  // main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(`IDX_TRIGGER, 32'h0);
    rdchk(`IDX_STATUS, 32'h0);
    rdchk(`IDX_COUNT, 32'h0);
    rdchk(8'h20, 32'h0);
    check(last_err, 1'b1);
    $display("done: reset values");
    for (int i = 0; i < 19; i++) begin
      xfer(1'b1, `IDX_TRIGGER, i < 18 ? rows[i][22:15] : 8'h80);
      xfer(1'b1, `IDX_CONTROL, 32'hc0);
      drive(i < 18 ? rows[i][14:8] : A | XA, 1);
      drive(i < 18 ? rows[i][7:1] : N, 1);
      xfer(1'b0, `IDX_STATUS, 32'h0);
      check(q[0], i < 18 ? !rows[i][0] : 1'b0);
      xfer(1'b1, `IDX_CONTROL, 32'h0);
    end
    $display("done: trigger modes");
    // drop events left over from the mode table
    xfer(1'b1, `IDX_IRQ_STATUS, 32'h7);
    xfer(1'b1, `IDX_IRQ_MASK, 32'h1);
    xfer(1'b1, `IDX_TRIGGER, 32'h41);
    xfer(1'b1, `IDX_CONTROL, 32'hc0);
    xfer(1'b1, `IDX_TRIGGER, 32'h07);
    check(last_err, 1'b0);
    rdchk(`IDX_TRIGGER, 32'h41);
    drive(WV, 3);
    rdchk(`IDX_COUNT, 32'h0);
    check(irq, 1'b0);
    drive(A, 1);
    check(irq, 1'b1);
    drive(WV, 10);
    rdchk(`IDX_COUNT, 32'h8);
    rdchk(`IDX_STATUS, 32'h80);
    xfer(1'b1, `IDX_IRQ_STATUS, 32'h1);
    check(irq, 1'b0);
    xfer(1'b1, `IDX_IRQ_MASK, 32'h2);
    check(irq, 1'b1);
    xfer(1'b1, `IDX_IRQ_MASK, 32'h4);
    check(irq, 1'b1);
    xfer(1'b1, `IDX_IRQ_MASK, 32'h0);
    check(irq, 1'b0);
    $display("done: begin run");
    xfer(1'b1, `IDX_TRIGGER, 32'h05);
    xfer(1'b1, `IDX_CONTROL, 32'hc0);
    rdchk(`IDX_COUNT, 32'h0);
    drive(WV | C, 10);
    rdchk(`IDX_COUNT, 32'h8);
    pulse_reset();
    rdchk(`IDX_COUNT, 32'h8);
    rdchk(`IDX_STATUS, 32'h20);
    rdchk(`IDX_TRIGGER, 32'h05);
    rdchk(`IDX_CONTROL, 32'h80);
    xfer(1'b1, `IDX_TRIGGER, 32'h45);
    pulse_reset();
    rdchk(`IDX_COUNT, 32'h0);
    rdchk(`IDX_TRIGGER, 32'h0);
    $display("done: run resets");
    xfer(1'b1, `IDX_CONTROL, 32'h40);
    drive(WV | A, 4);
    rdchk(`IDX_STATUS, 32'h0);
    rdchk(`IDX_COUNT, 32'h0);
    $display("done: disabled unit");
    test_done();
  end
endmodule // test_debug_trigger_status_count
`default_nettype wire
